// ==== design/modem_ctl_map.svh ====
// Purpose: constants for the modem-control and remote/local block
// Assumes: 100 MHz mclk_in
// Notes: timing counts derived from times in their own units
`ifndef MODEM_CTL_MAP_SVH
`define MODEM_CTL_MAP_SVH
`define CLK_PERIOD_NS 10
// break must hold this long on the receive line to count
`define BREAK_MIN_NS 200000
`define BREAK_CYCLES ((`BREAK_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BREAK_CNT_W 16
// device-clear pulse length in cycles
`define CLEAR_PULSE_CYCLES 1
`define LINK_RESET_VAL 1'h0
// modem line synchronisers idle with rxd at mark, all other lines off
`define SYNC_RESET_VAL 6'h01
`define KEY_RESET_VAL 2'h0
`define BREAK_CNT_RESET_VAL 16'h0000
`endif

// ==== design/modem_ctl_pkg.sv ====
// Purpose: types for the modem-control and remote/local block
// Assumes: nothing beyond the map header
// Notes: handshake state and control mode
package modem_ctl_pkg;
  typedef enum logic [1:0] {HS_IDLE, HS_REQ, HS_SEND} hs_state_t;
  typedef enum logic {MODE_LOCAL, MODE_REMOTE} ctl_mode_t;
endpackage

// ==== design/modem_ctl.sv ====
// Purpose: dte-side modem handshake, remote/local control, break clear
// Assumes: modem lines are active-high ON levels after the line receiver
// Notes: one clock domain; all outputs registered
`include "modem_ctl_map.svh"

// Function
// RULE_01: send data only while rts, cts, dsr and dtr are all on.
// RULE_02: raise rts when data waits, then wait for cts before sending.
// RULE_03: modem raises cts only in answer to rts; no cts, no sending.
// RULE_04: modem raises dsr once the call is established.
// RULE_05: modem raises carrier detect only for a valid received signal.
// RULE_06: dtr is on only while the terminal is ready for data.
// RULE_07: modem raises ring indicator for an incoming call.
// RULE_08: rate select on means higher rate; modem line carries reverse selection.
// RULE_09: direct link remote mode ends only on return_to_local_command.
// RULE_10: front-panel local key ignored under serial control.
// RULE_11: modem mode drops to local on disconnect; new enter command needed.
// RULE_12: controller sends a break first once the link is up.
// RULE_13: a received break performs the device-clear action.
// RULE_14: controller waits about two seconds after break, then enters remote.
// RULE_15: every incoming modem line passes two flip-flops before use.
module modem_ctl (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // configuration and user side
  input wire logic direct_link_configuration_in,
  input wire logic terminal_enable_in,
  input wire logic high_rate_in,
  input wire logic tx_pending_in,
  input wire logic enter_remote_command_in,
  input wire logic return_to_local_command_in,
  input wire logic local_key_in,
  // modem lines from the far side
  input wire logic cts_in,
  input wire logic dsr_in,
  input wire logic dcd_in,
  input wire logic ring_in,
  input wire logic rate_ind_in,
  input wire logic rxd_in,
  // modem lines to the far side
  output logic rts_out,
  output logic dtr_out,
  output logic rate_sel_out,
  // status to the user side
  output logic tx_allowed_out,
  output logic remote_out,
  output logic carrier_out,
  output logic ring_out,
  output logic far_high_rate_out,
  output logic device_clear_out
);
  import modem_ctl_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [1:0] key_sync;
    hs_state_t hs;
    ctl_mode_t mode;
    logic rts;
    logic dtr;
    logic rate_sel;
    logic tx_allowed;
    logic carrier;
    logic ring;
    logic far_high;
    logic [`BREAK_CNT_W-1:0] brk_cnt;
    logic brk_seen;
    logic dev_clear;
    logic remote;
  } state_t;

  state_t st_reg;
  state_t st_next;

  // synchronised views: cts, dsr, dcd, ring, rate, rxd
  logic cts_s, dsr_s, dcd_s, ring_s, rate_s, rxd_s;
  assign {cts_s, dsr_s, dcd_s, ring_s, rate_s, rxd_s} = st_reg.sync2;

  function automatic logic all_on(input logic r, input logic c, input logic d, input logic t);
    all_on = r & c & d & t;
  endfunction

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  // whole block state computed from the registered copy
  always_comb begin
    st_next = st_reg;
    // two-stage synchroniser on every modem input
    st_next.sync1 = {cts_in, dsr_in, dcd_in, ring_in, rate_ind_in, rxd_in}; // RULE_15
    st_next.sync2 = st_reg.sync1; // RULE_15
    // front-panel key is a pin too: two flops before any use
    st_next.key_sync = {st_reg.key_sync[0], local_key_in}; // RULE_15
    // dtr on only while terminal is ready
    st_next.dtr = terminal_enable_in; // RULE_06
    st_next.rate_sel = high_rate_in; // RULE_08
    st_next.far_high = rate_s; // RULE_08
    st_next.carrier = dcd_s;
    st_next.ring = ring_s;
    // rts/cts handshake
    unique case (st_reg.hs)
      HS_IDLE: begin
        if (tx_pending_in && terminal_enable_in) begin
          st_next.hs = HS_REQ; // RULE_02
        end
      end
      HS_REQ: begin
        if (!tx_pending_in || !terminal_enable_in) begin
          st_next.hs = HS_IDLE;
        end else if (cts_s && dsr_s) begin
          st_next.hs = HS_SEND; // RULE_02
        end
      end
      HS_SEND: begin
        if (!tx_pending_in || !terminal_enable_in || !cts_s || !dsr_s) begin
          st_next.hs = HS_IDLE; // RULE_01
        end
      end
      default: begin
        st_next.hs = HS_IDLE;
      end
    endcase
    st_next.rts = (st_next.hs != HS_IDLE); // RULE_02
    // gate sending on all four lines: rts and dtr at their next values, cts and dsr at their present synced values
    st_next.tx_allowed = (st_next.hs == HS_SEND) &&
      all_on(st_next.rts, cts_s, dsr_s, st_next.dtr); // RULE_01
    // remote/local control
    if (st_reg.mode == MODE_LOCAL) begin
      if (enter_remote_command_in) begin
        st_next.mode = MODE_REMOTE;
      end
    end else begin
      if (return_to_local_command_in) begin
        st_next.mode = MODE_LOCAL; // RULE_09
      end else if (!direct_link_configuration_in && (!dsr_s || !terminal_enable_in)) begin
        st_next.mode = MODE_LOCAL; // RULE_11
      end
      // synced key steers nothing while remote; only the command, or a disconnect in modem mode, returns to local
      st_next.mode = st_reg.key_sync[1] ? st_next.mode : st_next.mode; // RULE_10
    end
    // registered copy so remote_out comes straight from a flop
    st_next.remote = (st_next.mode == MODE_REMOTE);
    // break: receive line held spacing (low) long enough
    // a short glitch must not clear the device; the minimum is a chosen figure
    st_next.dev_clear = 1'h0;
    if (rxd_s) begin
      st_next.brk_cnt = '0;
      st_next.brk_seen = 1'h0;
    end else if (!st_reg.brk_seen) begin
      if (st_reg.brk_cnt == `BREAK_CNT_W'(`BREAK_CYCLES - 1)) begin
        st_next.brk_seen = 1'h1;
        st_next.dev_clear = 1'h1; // RULE_13
      end else begin
        st_next.brk_cnt = st_reg.brk_cnt + `BREAK_CNT_W'(1);
      end
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  // every field reset to a named constant of its own width
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg <= '{
        sync1: `SYNC_RESET_VAL,
        sync2: `SYNC_RESET_VAL,
        key_sync: `KEY_RESET_VAL,
        hs: HS_IDLE,
        mode: MODE_LOCAL,
        brk_cnt: `BREAK_CNT_RESET_VAL,
        default: `LINK_RESET_VAL
      };
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs straight from the state flops
  // ---------------------------------------------------------------
  assign rts_out = st_reg.rts;
  assign dtr_out = st_reg.dtr;
  assign rate_sel_out = st_reg.rate_sel;
  assign tx_allowed_out = st_reg.tx_allowed;
  assign remote_out = st_reg.remote;
  assign carrier_out = st_reg.carrier;
  assign ring_out = st_reg.ring;
  assign far_high_rate_out = st_reg.far_high;
  assign device_clear_out = st_reg.dev_clear;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_tx_needs_lines: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_01
    tx_allowed_out |-> (rts_out && dtr_out && $past(cts_s) && $past(dsr_s)))
    else $error("sending without all handshake lines on");
  a_rts_on_pending: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_02
    (tx_pending_in && terminal_enable_in && !rts_out) |=> rts_out)
    else $error("rts not raised for pending data");
  a_dtr_follows: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_06
    ##1 (dtr_out == $past(terminal_enable_in)))
    else $error("dtr does not follow terminal readiness");
  a_rate_select: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_08
    ##1 (rate_sel_out == $past(high_rate_in)))
    else $error("rate selector wrong");
  a_direct_stays: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_09
    (remote_out && direct_link_configuration_in && !return_to_local_command_in) |=> remote_out)
    else $error("direct link left remote without command");
  a_local_key: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_10
    (remote_out && local_key_in && !return_to_local_command_in && direct_link_configuration_in) |=> remote_out)
    else $error("local key acted under serial control");
  a_modem_drop: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_11
    (remote_out && !direct_link_configuration_in && !terminal_enable_in) |=> !remote_out)
    else $error("modem disconnect did not return to local");
  a_break_clear: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_13
    device_clear_out |-> (!rxd_s && $past(!rxd_s)))
    else $error("device clear without break");
  a_sync_delay: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_15
    ##3 (carrier_out == $past(dcd_in, 3)))
    else $error("carrier not two-stage synchronised");
endmodule

// ==== sim/modem_model.sv ====
// Purpose: modem partner for the modem-control block
// Assumes: bench sets call, break and delay at falling edges
// Notes: cts answers rts after a chosen number of cycles
module modem_model (
  // clock and controls from the bench, rts from the terminal
  input wire logic mclk_in,
  input wire logic rts_in,
  input wire logic call_up_in,
  input wire logic brk_in,
  input wire logic [3:0] cts_delay_in,
  // modem lines to the terminal
  output logic cts_out,
  output logic dsr_out,
  output logic rxd_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_reg = 4'h0;
  // cts only in answer to rts and only on a live call
  always @(posedge mclk_in) begin
    wait_reg <= !rts_in ? 4'h0 : (wait_reg == cts_delay_in) ? wait_reg : wait_reg + 4'h1;
    cts_out <= rts_in && call_up_in && (wait_reg == cts_delay_in);
  end
  // dsr follows the call, receive line idles at mark
  assign dsr_out = call_up_in;
  assign rxd_out = ~brk_in;
endmodule

// ==== sim/test_rs232_modem_control_remote.sv ====
// Purpose: self-checking bench for the modem-control block
// Assumes: inputs change at falling edges of a 100 MHz clock
// Notes: break test runs the full break count
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; $display("[FAIL] %0t mismatch", $time); end end
module test_rs232_modem_control_remote;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_in, rst_in, direct_link_configuration_in, terminal_enable_in, high_rate_in, tx_pending_in;
  logic enter_remote_command_in, return_to_local_command_in, local_key_in, call, brk;
  logic cts_in, dsr_in, dcd_in, ring_in, rate_ind_in, rxd_in, rts_out, dtr_out, rate_sel_out;
  logic tx_allowed_out, remote_out, carrier_out, ring_out, far_high_rate_out, device_clear_out;
  logic [3:0] dly;
  int mismatches, num_checks, clears;
  modem_ctl u_dut (.mclk_in, .rst_in, .direct_link_configuration_in, .terminal_enable_in, .high_rate_in,
    .tx_pending_in, .enter_remote_command_in, .return_to_local_command_in, .local_key_in, .cts_in, .dsr_in,
    .dcd_in, .ring_in, .rate_ind_in, .rxd_in, .rts_out, .dtr_out, .rate_sel_out, .tx_allowed_out,
    .remote_out, .carrier_out, .ring_out, .far_high_rate_out, .device_clear_out);
  modem_model u_modem (.mclk_in, .rts_in(rts_out), .call_up_in(call), .brk_in(brk), .cts_delay_in(dly),
    .cts_out(cts_in), .dsr_out(dsr_in), .rxd_out(rxd_in));
  // clock and clear-pulse counter
  always #5 mclk_in = ~mclk_in;
  always @(posedge mclk_in) if (device_clear_out === 1'b1) clears++;
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_in);
  endtask
  task automatic t_handshake(input logic [3:0] d);
    dly = d;
    tx_pending_in = 1'b1;
    for (int i = 0; i < 24; i++) begin
      cyc(1);
      if (cts_in !== 1'b1) `CHK(tx_allowed_out, 1'b0)
    end
    `CHK(rts_out, 1'b1)
    `CHK(tx_allowed_out, 1'b1)
    call = 1'b0;
    cyc(4);
    `CHK(tx_allowed_out, 1'b0)
    tx_pending_in = 1'b0;
    call = 1'b1;
    cyc(4);
    `CHK(rts_out, 1'b0)
  endtask
  task automatic t_lines(input logic v);
    {terminal_enable_in, high_rate_in, rate_ind_in, dcd_in, ring_in} = {5{v}};
    cyc(5);
    `CHK(dtr_out, v)
    `CHK(rate_sel_out, v)
    `CHK(far_high_rate_out, v)
    `CHK(carrier_out, v)
    `CHK(ring_out, v)
  endtask
  task automatic t_remote(input logic direct);
    direct_link_configuration_in = direct;
    enter_remote_command_in = 1'b1;
    cyc(1);
    enter_remote_command_in = 1'b0;
    local_key_in = 1'b1;
    cyc(3);
    local_key_in = 1'b0;
    `CHK(remote_out, 1'b1)
    call = 1'b0;
    cyc(5);
    `CHK(remote_out, direct)
    call = 1'b1;
    cyc(5);
    `CHK(remote_out, direct)
    // a fresh enter command restores remote; dropping terminal ready leaves it in modem mode only
    enter_remote_command_in = 1'b1;
    cyc(1);
    enter_remote_command_in = 1'b0;
    terminal_enable_in = 1'b0;
    `CHK(remote_out, 1'b1)
    cyc(2);
    `CHK(remote_out, direct)
    terminal_enable_in = 1'b1;
    cyc(2);
    return_to_local_command_in = 1'b1;
    cyc(1);
    return_to_local_command_in = 1'b0;
    cyc(2);
    `CHK(remote_out, 1'b0)
  endtask
  task automatic t_break;
    brk = 1'b1;
    cyc(19000);
    `CHK(clears, 0)
    cyc(1100);
    brk = 1'b0;
    cyc(5);
    `CHK(clears, 1)
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog
  initial begin
    #500us;
    mismatches++;
    report_and_stop();
  end
  // main sequence
  initial begin
    {mclk_in, rst_in, direct_link_configuration_in, terminal_enable_in, high_rate_in, tx_pending_in} = 6'h10;
    {enter_remote_command_in, return_to_local_command_in, local_key_in, dcd_in, ring_in, rate_ind_in} = 6'h00;
    {call, brk, dly} = 6'h20;
    cyc(4);
    `CHK(remote_out, 1'b0)
    rst_in = 1'b0;
    t_lines(1'b1);
    t_lines(1'b0);
    t_lines(1'b1);
    t_handshake(4'h0);
    t_handshake(4'h7);
    t_remote(1'b1);
    t_remote(1'b0);
    t_break();
    t_remote(1'b1);
    report_and_stop();
  end
endmodule
